// [shared/cal_seq_params.svh]
// timing counts and mode codes for the calibration and sleep sequencer
`ifndef CAL_SEQ_PARAMS_SVH
`define CAL_SEQ_PARAMS_SVH
`define MODE_NORMAL 3'h0
`define MODE_PSEUDO 3'h4
`define MODE_BACKGROUND 3'h5
`define MODE_SLEEP 3'h6
`define CAL_PERIODS 3'h3
`define CAL_PERIODS_SLAVE 3'h4
`define FILL_PERIODS 3'h3
`define BG_RATE_DIV 3'h6
`define WAKE_PU_CYCLES 8'h10
`define CONV_DIV_DEFAULT 16
`define WAKE_EDGE_MIN 2
`endif

// [shared/cal_seq_pkg.sv]
// types for the calibration and sleep sequencer
package cal_seq_pkg;
    typedef enum logic [7:0] {
        ST_NORMAL = 8'b0000_0001,
        ST_OFFSET = 8'b0000_0010,
        ST_GAIN = 8'b0000_0100,
        ST_FILL = 8'b0000_1000,
        ST_SLEEP = 8'b0001_0000,
        ST_POWERUP = 8'b0010_0000,
        ST_WAKECONV = 8'b0100_0000,
        ST_HOLD = 8'b1000_0000
    } seq_state_e;
    typedef struct packed {
        logic short_inputs;
        logic ref_connect;
        logic analog_on;
        logic digital_on;
    } analog_ctrl_s;
endpackage

// [logic/conv_strobe.sv]
// conversion-period strobe divider from the master clock
`timescale 1ns/1ps
module conv_strobe #(
    parameter int DIV = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    output logic strobe
);
    localparam int W = $clog2(DIV + 1);
    logic [W-1:0] cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            strobe <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            strobe <= 1'b0;
        end else if (cnt_q == W'(DIV - 1)) begin
            cnt_q <= '0;
            strobe <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            strobe <= 1'b0;
        end
    end
endmodule

// [logic/cal_sleep_seq.sv]
// calibration, background and sleep mode sequencer
// Function
// - mode 100 starts pseudo calibration on the next conversion strobe
// - result valid held high during pseudo calibration
// - pseudo offset three periods, four slave
// - then reference gain calibration three periods
// - clear mode, three fills, then valid
// - mode 101 enters background calibration
// - background offset three, first slave four
// - fills, valid, then gain calibration
// - fills, valid, then next offset, repeat
// - background data rate is one sixth
// - background stays until new mode written
// - mode 110 sleeps until new mode
// - sleep powers down analog and digital
// - select low during sleep allows communication
// - slave instruction restores communication in sleep
// - power-up, one conversion, then new mode
// - valid high through two wake conversions
`timescale 1ns/1ps
`include "cal_seq_params.svh"
module cal_sleep_seq
    import cal_seq_pkg::*;
#(
    parameter int CONV_DIV = `CONV_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] mode_wr_data,
    input wire logic mode_wr,
    input wire logic slave_mode,
    input wire logic select_n,
    input wire logic data_in,
    input wire logic instr_cmd,
    input wire logic internal_ref_enable,
    input wire logic bias_enable,
    output logic [2:0] op_mode,
    output logic result_valid_n,
    output logic comm_enable,
    output logic [3:0] analog_ctrl,
    output logic internal_ref_on,
    output logic bias_on,
    output logic conv_tick,
    output logic cal_active
);
    seq_state_e state_q;
    seq_state_e ret_q;
    logic [2:0] mode_q;
    logic [2:0] cnt_q;
    logic [7:0] pu_q;
    logic first_off_q;
    logic bg_q;
    logic gain_next_q;
    logic strobe;
    logic [2:0] sel_s;
    logic [2:0] dat_s;
    logic data_fall_q;
    logic [1:0] hi_cnt_q;
    logic hi_armed_q;
    analog_ctrl_s ac_d;

    function automatic logic [2:0] offset_len(input logic slv,
                                              input logic first);
        offset_len = (slv && first) ? `CAL_PERIODS_SLAVE : `CAL_PERIODS;
    endfunction

    // divider stops in sleep so digital logic idles
    conv_strobe #(.DIV(CONV_DIV)) u_div (
        .clk(clk),
        .nrst(nrst),
        .run(state_q != ST_SLEEP && state_q != ST_POWERUP),
        .strobe(strobe)
    );

    // pin inputs pass three flops; stage 0 read only by stage 1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_s <= 3'h7;
            dat_s <= 3'h0;
        end else begin
            sel_s <= {sel_s[1:0], select_n};
            dat_s <= {dat_s[1:0], data_in};
        end
    end

    // data line wake: high for two clocks or more, then falling
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_cnt_q <= 2'h0;
            hi_armed_q <= 1'b0;
            data_fall_q <= 1'b0;
        end else begin
            data_fall_q <= 1'b0;
            // stage 1 sees one sample per clock the pin was high
            if (dat_s[1]) begin
                if (hi_cnt_q != 2'(`WAKE_EDGE_MIN))
                    hi_cnt_q <= hi_cnt_q + 2'h1;
                if (hi_cnt_q == 2'(`WAKE_EDGE_MIN - 1))
                    hi_armed_q <= 1'b1;
            end else begin
                hi_cnt_q <= 2'h0;
                if (!dat_s[2]) begin
                    hi_armed_q <= 1'b0;
                    data_fall_q <= hi_armed_q;
                end
            end
        end
    end

    // ret_q holds last cycle's state, so this is the first sleep cycle
    function automatic logic strobe_sleep_entry();
        strobe_sleep_entry = (ret_q != ST_SLEEP);
    endfunction

    // communication gate: closes on sleep entry, held until a wake event
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            comm_enable <= 1'b1;
        end else if (state_q != ST_SLEEP) begin
            comm_enable <= 1'b1;
        end else if (!sel_s[1] && !sel_s[2]) begin
            comm_enable <= 1'b1;
        end else if (data_fall_q && !slave_mode) begin
            comm_enable <= 1'b1;
        end else if (instr_cmd && slave_mode) begin
            comm_enable <= 1'b1;
        end else if (strobe_sleep_entry()) begin
            comm_enable <= 1'b0;
        end
    end

    // mode field: host writes, hardware clears after pseudo calibration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= `MODE_NORMAL;
        end else if (mode_wr && (state_q != ST_SLEEP || comm_enable)) begin
            mode_q <= mode_wr_data;
        end else if (state_q == ST_GAIN && strobe && cnt_q == 3'h1 &&
                     !bg_q) begin
            mode_q <= `MODE_NORMAL;
        end
    end

    // main sequencer; every step except sleep and power-up advances on conversion strobe only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_NORMAL;
            ret_q <= ST_NORMAL;
            cnt_q <= 3'h0;
            pu_q <= 8'h00;
            first_off_q <= 1'b1;
            bg_q <= 1'b0;
            gain_next_q <= 1'b0;
        end else begin
            ret_q <= state_q;
            case (state_q)
                ST_NORMAL, ST_HOLD: begin
                    if (strobe) begin
                        if (mode_q == `MODE_PSEUDO) begin
                            state_q <= ST_OFFSET;
                            bg_q <= 1'b0;
                            cnt_q <= offset_len(slave_mode, 1'b1);
                        end else if (mode_q == `MODE_BACKGROUND) begin
                            state_q <= ST_OFFSET;
                            bg_q <= 1'b1;
                            first_off_q <= 1'b0;
                            cnt_q <= offset_len(slave_mode, 1'b1);
                        end else if (mode_q == `MODE_SLEEP) begin
                            state_q <= ST_SLEEP;
                        end else begin
                            state_q <= ST_NORMAL;
                        end
                    end
                end
                ST_OFFSET: begin
                    if (strobe) begin
                        if (bg_q && mode_q != `MODE_BACKGROUND) begin
                            state_q <= ST_NORMAL;
                        end else if (cnt_q == 3'h1) begin
                            if (bg_q) begin
                                state_q <= ST_FILL;
                                gain_next_q <= 1'b1;
                                cnt_q <= `FILL_PERIODS;
                            end else begin
                                state_q <= ST_GAIN;
                                cnt_q <= `CAL_PERIODS;
                            end
                        end else begin
                            cnt_q <= cnt_q - 3'h1;
                        end
                    end
                end
                ST_GAIN: begin
                    if (strobe) begin
                        if (bg_q && mode_q != `MODE_BACKGROUND) begin
                            state_q <= ST_NORMAL;
                        end else if (cnt_q == 3'h1) begin
                            state_q <= ST_FILL;
                            gain_next_q <= 1'b0;
                            cnt_q <= `FILL_PERIODS;
                        end else begin
                            cnt_q <= cnt_q - 3'h1;
                        end
                    end
                end
                ST_FILL: begin
                    if (strobe) begin
                        if (cnt_q != 3'h1) begin
                            cnt_q <= cnt_q - 3'h1;
                        end else if (!bg_q ||
                                     mode_q != `MODE_BACKGROUND) begin
                            state_q <= ST_NORMAL;
                        end else if (gain_next_q) begin
                            // valid cycle doubles as first gain period
                            state_q <= ST_GAIN;
                            cnt_q <= `CAL_PERIODS;
                        end else begin
                            state_q <= ST_OFFSET;
                            cnt_q <= offset_len(slave_mode, first_off_q);
                        end
                    end
                end
                ST_SLEEP: begin
                    if (mode_q != `MODE_SLEEP) begin
                        state_q <= ST_POWERUP;
                        pu_q <= `WAKE_PU_CYCLES;
                    end
                end
                ST_POWERUP: begin
                    if (pu_q == 8'h01) begin
                        state_q <= ST_WAKECONV;
                    end else begin
                        pu_q <= pu_q - 8'h01;
                    end
                end
                ST_WAKECONV: begin
                    if (strobe) begin
                        state_q <= ST_HOLD;
                        first_off_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_NORMAL;
                end
            endcase
        end
    end

    // valid strobe low on a normal or hold cycle edge in normal mode, or on the last fill edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_valid_n <= 1'b1;
        end else if (state_q == ST_NORMAL && strobe &&
                     mode_q == `MODE_NORMAL) begin
            result_valid_n <= 1'b0;
        end else if (state_q == ST_FILL && strobe && cnt_q == 3'h1) begin
            result_valid_n <= 1'b0;
        end else if (state_q == ST_HOLD && strobe &&
                     mode_q == `MODE_NORMAL) begin
            result_valid_n <= 1'b0;
        end else if (strobe || state_q == ST_SLEEP) begin
            result_valid_n <= 1'b1;
        end
    end

    // analog switch and power control
    always_comb begin
        ac_d.short_inputs = (state_q == ST_OFFSET) && bg_q;
        ac_d.ref_connect = (state_q == ST_GAIN);
        ac_d.analog_on = (state_q != ST_SLEEP);
        ac_d.digital_on = (state_q != ST_SLEEP);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            analog_ctrl <= 4'h0;
            op_mode <= `MODE_NORMAL;
            internal_ref_on <= 1'b0;
            bias_on <= 1'b0;
            conv_tick <= 1'b0;
            cal_active <= 1'b0;
        end else begin
            analog_ctrl <= ac_d;
            op_mode <= mode_q;
            // enables follow host bits only; nothing restores them
            internal_ref_on <= internal_ref_enable;
            bias_on <= bias_enable;
            conv_tick <= strobe;
            cal_active <= (state_q == ST_OFFSET) || (state_q == ST_GAIN);
        end
    end

    a_pseudo_start: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_NORMAL && strobe && mode_q == `MODE_PSEUDO) |=>
        state_q == ST_OFFSET)
        else $error("pseudo calibration did not start");
    // background valid cycles overlap its phases, so pseudo only
    a_cal_valid_hi: assert property (@(posedge clk) disable iff (!nrst)
        ((state_q == ST_OFFSET || state_q == ST_GAIN) && !bg_q) |->
        result_valid_n)
        else $error("result valid low during calibration");
    a_gain_ref_sw: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_GAIN) |=> analog_ctrl[2])
        else $error("reference not connected in gain phase");
    a_pseudo_clear: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_GAIN && strobe && cnt_q == 3'h1 && !bg_q &&
         !mode_wr) |=> mode_q == `MODE_NORMAL)
        else $error("mode not cleared after pseudo calibration");
    sequence s_fill_last;
        state_q == ST_FILL && strobe && cnt_q == 3'h1;
    endsequence
    a_fill_valid: assert property (@(posedge clk) disable iff (!nrst)
        s_fill_last |=> !result_valid_n)
        else $error("valid not flagged after fill");
    a_bg_enter: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_NORMAL && strobe && mode_q == `MODE_BACKGROUND) |=>
        (state_q == ST_OFFSET && bg_q))
        else $error("background mode not entered");
    a_sleep_power: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_SLEEP) |=> !analog_ctrl[1])
        else $error("analog not off in sleep");
    a_wake_hold: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_WAKECONV) |=> result_valid_n)
        else $error("valid low in first wake conversion");
    a_ref_follow: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> internal_ref_on == $past(internal_ref_enable))
        else $error("reference enable not host driven");
endmodule

// [verification/host_model.sv]
// host controller model driving mode writes and wake-up lines
`timescale 1ns/1ps
`include "cal_seq_params.svh"
module host_model (
    input wire logic clk,
    output logic [2:0] mode_wr_data,
    output logic mode_wr,
    output logic slave_mode,
    output logic select_n,
    output logic data_in,
    output logic instr_cmd,
    output logic internal_ref_enable,
    output logic bias_enable
);
    initial begin
        mode_wr_data = 3'h0;
        mode_wr = 1'h0;
        slave_mode = 1'h0;
        select_n = 1'h1;
        data_in = 1'h0;
        instr_cmd = 1'h0;
        internal_ref_enable = 1'h1;
        bias_enable = 1'h1;
    end
    // only a different code leaves background or sleep
    task automatic write_mode(input logic [2:0] code);
        @(negedge clk);
        mode_wr_data = code;
        mode_wr = 1'h1;
        @(negedge clk);
        mode_wr = 1'h0;
    endtask
    task automatic set_slave(input logic v);
        @(negedge clk);
        slave_mode = v;
    endtask
    // device never restores these, so the host sets them
    task automatic set_enables(input logic on);
        @(negedge clk);
        internal_ref_enable = on;
        bias_enable = on;
    endtask
    // raised before sleep so a later fall ends it
    task automatic hold_data_high();
        @(negedge clk);
        data_in = 1'h1;
    endtask
    // kind 0 select, 1 data pulse, 2 data held, 3 instruction
    task automatic wake(input int kind);
        @(negedge clk);
        case (kind)
            0: select_n = 1'h0;
            1: begin
                data_in = 1'h1;
                repeat (`WAKE_EDGE_MIN) @(negedge clk);
                data_in = 1'h0;
            end
            2: data_in = 1'h0;
            default: instr_cmd = 1'h1;
        endcase
        @(negedge clk);
        instr_cmd = 1'h0;
    endtask
    task automatic release_lines();
        @(negedge clk);
        select_n = 1'h1;
        data_in = 1'h0;
    endtask
endmodule

// [verification/tb_cal_sleep_seq.sv]
// self-checking bench for the calibration and sleep sequencer
`timescale 1ns/1ps
`include "cal_seq_params.svh"
module tb_cal_sleep_seq;
    import cal_seq_pkg::*;
    // short divider keeps the run brief
    localparam int DIV = 4;
    logic clk, nrst, mode_wr, slave_mode, select_n, data_in, instr_cmd;
    logic internal_ref_enable, bias_enable, result_valid_n, comm_enable;
    logic internal_ref_on, bias_on, conv_tick, cal_active;
    logic [2:0] mode_wr_data, op_mode;
    logic [3:0] analog_ctrl;
    analog_ctrl_s ctl;
    int fail_count = 0, compares = 0, cycles = 0, rv_low, ref_hi, sh_hi, n;
    assign ctl = analog_ctrl;
    cal_sleep_seq #(.CONV_DIV(DIV)) cal_sleep_seq_i (.clk(clk), .nrst(nrst),
        .mode_wr_data(mode_wr_data), .mode_wr(mode_wr),
        .slave_mode(slave_mode), .select_n(select_n), .data_in(data_in),
        .instr_cmd(instr_cmd), .internal_ref_enable(internal_ref_enable),
        .bias_enable(bias_enable), .op_mode(op_mode),
        .result_valid_n(result_valid_n), .comm_enable(comm_enable),
        .analog_ctrl(analog_ctrl), .internal_ref_on(internal_ref_on),
        .bias_on(bias_on), .conv_tick(conv_tick), .cal_active(cal_active));
    host_model host_model_i (.clk(clk), .mode_wr_data(mode_wr_data),
        .mode_wr(mode_wr), .slave_mode(slave_mode), .select_n(select_n),
        .data_in(data_in), .instr_cmd(instr_cmd),
        .internal_ref_enable(internal_ref_enable), .bias_enable(bias_enable));
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (e !== g) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // which: 0 cal_active, 1 result_valid_n, 2 comm_enable
    task automatic wait_sig(input int which, input logic v, output int c);
        logic s;
        c = 0;
        forever begin
            s = which == 0 ? cal_active :
                which == 1 ? result_valid_n : comm_enable;
            if (s === v || c >= 400) break;
            @(negedge clk);
            c++;
            rv_low += int'(result_valid_n === 1'h0);
            ref_hi += int'(ctl.ref_connect === 1'h1);
            sh_hi += int'(ctl.short_inputs === 1'h1);
        end
        if (c >= 400) chk("wait", 1, 0);
    endtask
    task automatic t_pseudo(input logic slv);
        host_model_i.set_slave(slv);
        host_model_i.write_mode(`MODE_PSEUDO);
        repeat (2) @(negedge clk);
        chk("op_mode", `MODE_PSEUDO, op_mode);
        wait_sig(0, 1'h1, n);
        chk("cal start", 1, n <= 2 * DIV);
        rv_low = 0;
        ref_hi = 0;
        sh_hi = 0;
        wait_sig(0, 1'h0, n);
        chk("cal len", ((slv ? `CAL_PERIODS_SLAVE : `CAL_PERIODS)
            + `CAL_PERIODS) * DIV, n);
        chk("gain len", `CAL_PERIODS * DIV, ref_hi);
        chk("short", 0, sh_hi);
        chk("rv in cal", 0, rv_low);
        chk("mode clr", `MODE_NORMAL, op_mode);
        wait_sig(1, 1'h0, n);
        // cal_active trails the state by one clock
        chk("fill len", `FILL_PERIODS * DIV - 1, n);
    endtask
    task automatic t_background(input logic slv);
        int a;
        host_model_i.set_slave(slv);
        host_model_i.write_mode(`MODE_BACKGROUND);
        wait_sig(0, 1'h1, n);
        rv_low = 0;
        // short rises with cal_active, so this edge already counts
        sh_hi = int'(ctl.short_inputs === 1'h1);
        wait_sig(0, 1'h0, n);
        a = slv ? `CAL_PERIODS_SLAVE : `CAL_PERIODS;
        chk("bg offset", a * DIV, n);
        chk("bg short", a * DIV, sh_hi);
        chk("bg rv", 0, rv_low);
        wait_sig(1, 1'h0, n);
        chk("bg fill", `FILL_PERIODS * DIV - 1, n);
        ref_hi = 0;
        wait_sig(1, 1'h1, a);
        chk("gain start", 1, cal_active);
        wait_sig(1, 1'h0, n);
        chk("bg rate", `BG_RATE_DIV * DIV, a + n);
        chk("bg gain", `CAL_PERIODS * DIV, ref_hi);
        wait_sig(0, 1'h1, n);
        // offset starts with the valid edge, flagged one clock later
        chk("offs again", 1, n == 1);
        wait_sig(0, 1'h0, n);
        chk("bg offset2", `CAL_PERIODS * DIV, n);
        chk("bg stays", `MODE_BACKGROUND, op_mode);
        host_model_i.write_mode(`MODE_NORMAL);
        repeat (2) @(negedge clk);
        chk("bg left", `MODE_NORMAL, op_mode);
        wait_sig(1, 1'h0, n);
    endtask
    task automatic t_sleep(input int kind);
        host_model_i.set_slave(kind == 3);
        host_model_i.set_enables(1'h0);
        if (kind == 2) host_model_i.hold_data_high();
        host_model_i.write_mode(`MODE_SLEEP);
        repeat (2) @(negedge clk);
        chk("sleep mode", `MODE_SLEEP, op_mode);
        wait_sig(2, 1'h0, n);
        chk("analog off", 0, ctl.analog_on);
        chk("ref off", 0, {internal_ref_on, bias_on});
        // write before any wake must be ignored
        host_model_i.write_mode(`MODE_NORMAL);
        repeat (2 * DIV) @(negedge clk);
        chk("refused", `MODE_SLEEP, op_mode);
        host_model_i.wake(kind);
        wait_sig(2, 1'h1, n);
        chk("wake", 1, n < 20);
        host_model_i.write_mode(`MODE_NORMAL);
        wait_sig(1, 1'h0, n);
        // margin of two clocks for write latency
        chk("wake rv", 1, n >= `WAKE_PU_CYCLES + 2 * DIV - 2);
        chk("analog on", 1, ctl.analog_on);
        chk("ref kept", 0, internal_ref_on);
        host_model_i.set_enables(1'h1);
        host_model_i.release_lines();
        repeat (3) @(negedge clk);
        chk("ref back", 3, {internal_ref_on, bias_on});
    endtask
    initial begin
        nrst = 1'h0;
        repeat (6) @(negedge clk);
        nrst = 1'h1;
        wait_sig(1, 1'h0, n);
        t_pseudo(1'h0);
        t_pseudo(1'h1);
        t_background(1'h0);
        t_background(1'h1);
        for (int k = 0; k < 4; k++) begin
            t_sleep(k);
        end
        stop_test();
    end
endmodule
